/* File: common/pbseq_pkg.sv */
// package of states, timing constants and pin levels for the pushbutton power sequencer
package pbseq_pkg;

  // ************************************************************
  // states
  // ************************************************************
  typedef enum logic [2:0] {
    hard_reset_state,
    powered_off_state,
    first_power_up_state,
    second_power_up_state,
    powered_on_state,
    timed_power_down_state,
    hard_power_down_state
  } seq_state_t;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned SYS_CLK_HZ      = 100_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = SYS_CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned DEBOUNCE_MS     = 50;
  localparam int unsigned PRESS_MS        = 400;
  localparam int unsigned EXT_SETTLE_MS   = 100;
  localparam int unsigned POWER_DOWN_MS   = 1000;
  localparam int unsigned POWER_UP_MS     = 5000;
  localparam int unsigned POWER_GOOD_OUT_DELAY_MS  = 230;
  localparam int unsigned LONG_PRESS_MS   = 5000;
  localparam int unsigned LONG_PRESS_X_MS = 14000;
  localparam int unsigned TICK_PER_MS     = 1000 / TICK_US;
  localparam int unsigned CNT_W           = 16;

  // ************************************************************
  // pin levels
  // ************************************************************
  localparam logic PIN_LOW   = 1'b0;
  localparam logic OE_DRIVE  = 1'b0;
  localparam logic OE_RELEASE = 1'b1;

endpackage : pbseq_pkg

/* File: rtl/pbseq_timer.sv */
// qualified-time counter: counts ticks while a condition holds, restarts when it drops
module pbseq_timer #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             arst_n_in,
  // control
  input  wire logic             tick_in,
  input  wire logic             run_in,
  input  wire logic [WIDTH-1:0] limit_in,
  // status
  output logic                  done_out
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_done;

  initial begin
    if (WIDTH < 2) $error("pbseq_timer width too small");
  end

  always_comb begin
    next_count = count;
    next_done  = done_out;
    if (!run_in) begin
      next_count = '0;
      next_done  = 1'b0;
    end else if (tick_in && !done_out) begin
      next_count = count + WIDTH'(1);
      next_done  = (next_count >= limit_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count    <= '0;
      done_out <= 1'b0;
    end else begin
      count    <= next_count;
      done_out <= next_done;
    end
  end

endmodule : pbseq_timer

/* File: rtl/pbseq_core.sv */
// pushbutton power sequencer state machine with regulator, status and power-good control
// Summary of operation
// - button low 50ms while on gives a debounced low pulse on status output
// - powered on, both power requests low: go to timed power-down
// - timed power-down waits one second, then goes to powered off
// - during power-down wait, requests, external power and button are ignored, except a long press begun while on
// - button held through power-down must go high, then low 400ms, to power up
// - undervoltage while powered on: timed power-down, power-good low, regulators off
// - wait ends with external power and no undervoltage: via off into second power-up
// - from off, a request high without undervoltage: straight to on, requested regulators
// - output below reset level: hard power-down, hard reset one second later
// - button low 5s (14s variant) raises long-press reset: hard power-down, all off
// - one second in hard power-down, then hard reset state
// - sequenced variant: after 400ms press enable regulator one only
// - regulator two enabled once regulator one is in regulation
// - power-good released 230ms after enabled regulators are in regulation
// - simultaneous variant: both regulators enabled together on power-up
// - both power-up states keep regulators on five seconds, then powered on
// - status output released in hard reset, off and both power-down states
// - from hard reset or off, 400ms press or external power starts power-up
module pbseq_core #(
  parameter bit          LONG_TIMEOUT = 1'b0,
  parameter bit          SIMULTANEOUS = 1'b0,
  parameter int unsigned TICK_CYCLES  = pbseq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  // pins and detectors
  input  wire logic button_n_in,
  input  wire logic power_request_one_in,
  input  wire logic power_request_two_in,
  input  wire logic ext_power_in,
  input  wire logic out_undervoltage_in,
  input  wire logic out_por_in,
  input  wire logic reg_one_good_in,
  input  wire logic reg_two_good_in,
  // regulator enables
  output logic      reg_one_enable_out,
  output logic      reg_two_enable_out,
  // open-drain status pins, driven low when enable is low
  output logic      button_status_out,
  output logic      button_status_oe_n_out,
  output logic      power_good_out,
  output logic      power_good_oe_n_out,
  // state visibility
  output logic      powered_out
);

  localparam int unsigned TW = pbseq_pkg::CNT_W;

  initial begin
    if (TICK_CYCLES < 2) $error("tick divider too small");
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] raw_pins;
  assign raw_pins = {out_por_in, out_undervoltage_in, ext_power_in, power_request_two_in,
                     power_request_one_in, button_n_in, reg_two_good_in, reg_one_good_in};
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= 8'h04;
      sync_b <= 8'h04;
    end else begin
      sync_a <= raw_pins;
      sync_b <= sync_a;
    end
  end
  logic one_good, two_good, button_low, req_one, req_two, ext_pwr, uv, por;
  assign one_good   = sync_b[0];
  assign two_good   = sync_b[1];
  assign button_low = ~sync_b[2];
  assign req_one    = sync_b[3];
  assign req_two    = sync_b[4];
  assign ext_pwr    = sync_b[5];
  assign uv         = sync_b[6];
  assign por        = sync_b[7];

  // ************************************************************
  // slow tick, one per millisecond
  // ************************************************************
  logic [31:0] div;
  logic [31:0] next_div;
  logic        tick;
  logic        next_tick;
  always_comb begin
    next_tick = (div == 32'(TICK_CYCLES - 1));
    next_div  = next_tick ? '0 : div + 32'h0000_0001;
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      div  <= next_div;
      tick <= next_tick;
    end
  end

  // ************************************************************
  // timers
  // ************************************************************
  pbseq_pkg::seq_state_t state;
  pbseq_pkg::seq_state_t next_state;

  function automatic logic [TW-1:0] ms(input int unsigned t);
    ms = TW'(t * pbseq_pkg::TICK_PER_MS);
  endfunction : ms

  function automatic logic is_on_group(input pbseq_pkg::seq_state_t s);
    is_on_group = (s == pbseq_pkg::powered_on_state)
               || (s == pbseq_pkg::first_power_up_state)
               || (s == pbseq_pkg::second_power_up_state);
  endfunction : is_on_group

  logic in_on_group, in_down, armed, next_armed, lp_valid, next_lp_valid;
  logic button_was_high, next_button_was_high;
  logic deb_done, press_done, ext_done, wait_done, pup_done, pg_done, lp_done, hold_done;
  logic all_good;
  logic bs_driving;
  assign in_on_group = is_on_group(state);
  assign bs_driving  = (button_status_oe_n_out == pbseq_pkg::OE_DRIVE);
  assign in_down = (state == pbseq_pkg::timed_power_down_state)
                || (state == pbseq_pkg::hard_power_down_state);
  assign all_good = (!reg_one_enable_out || one_good) && (!reg_two_enable_out || two_good)
                 && (reg_one_enable_out || reg_two_enable_out);

  pbseq_timer #(.WIDTH(TW)) u_deb (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(button_low && in_on_group && lp_valid),
    .limit_in(ms(pbseq_pkg::DEBOUNCE_MS)), .done_out(deb_done));
  pbseq_timer #(.WIDTH(TW)) u_hold (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(bs_driving && in_on_group),
    .limit_in(ms(pbseq_pkg::DEBOUNCE_MS)), .done_out(hold_done));
  pbseq_timer #(.WIDTH(TW)) u_press (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(button_low && armed),
    .limit_in(ms(pbseq_pkg::PRESS_MS)), .done_out(press_done));
  pbseq_timer #(.WIDTH(TW)) u_ext (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(ext_pwr && !in_down),
    .limit_in(ms(pbseq_pkg::EXT_SETTLE_MS)), .done_out(ext_done));
  pbseq_timer #(.WIDTH(TW)) u_wait (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(in_down && next_state == state),
    .limit_in(ms(pbseq_pkg::POWER_DOWN_MS)), .done_out(wait_done));
  pbseq_timer #(.WIDTH(TW)) u_pup (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(in_on_group && state != pbseq_pkg::powered_on_state),
    .limit_in(ms(pbseq_pkg::POWER_UP_MS)), .done_out(pup_done));
  pbseq_timer #(.WIDTH(TW)) u_pg (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(all_good && in_on_group),
    .limit_in(ms(pbseq_pkg::POWER_GOOD_OUT_DELAY_MS)), .done_out(pg_done));
  pbseq_timer #(.WIDTH(TW)) u_lp (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .tick_in(tick), .run_in(button_low && lp_valid),
    .limit_in(LONG_TIMEOUT ? ms(pbseq_pkg::LONG_PRESS_X_MS) : ms(pbseq_pkg::LONG_PRESS_MS)),
    .done_out(lp_done));

  // ************************************************************
  // state machine
  // ************************************************************
  logic long_press_reset_event, press_qualified_event;
  assign long_press_reset_event = lp_done;
  assign press_qualified_event  = press_done;

  always_comb begin
    next_state = state;
    // armed: button must be seen high before a new press counts
    next_armed = armed;
    if (!button_low) next_armed = 1'b1;
    else if (in_down || in_on_group) next_armed = 1'b0;
    // long press qualifies only if it began in a power-up or on state
    next_lp_valid = lp_valid;
    // only a press that starts here counts, not the one that powered the block up
    if (!button_low) next_lp_valid = 1'b0;
    else if (in_on_group && button_was_high) next_lp_valid = 1'b1;
    next_button_was_high = !button_low;
    if (por && state != pbseq_pkg::hard_reset_state) begin
      if (state != pbseq_pkg::hard_power_down_state)
        next_state = pbseq_pkg::hard_power_down_state;
    end else if (long_press_reset_event && state != pbseq_pkg::hard_power_down_state
                 && state != pbseq_pkg::hard_reset_state) begin
      next_state    = pbseq_pkg::hard_power_down_state;
      next_lp_valid = 1'b0;
    end else begin
      unique case (state)
        pbseq_pkg::hard_reset_state, pbseq_pkg::powered_off_state: begin
          if ((req_one || req_two) && !uv) next_state = pbseq_pkg::powered_on_state;
          else if (press_qualified_event || (ext_done && !uv))
            next_state = (state == pbseq_pkg::hard_reset_state)
                       ? pbseq_pkg::first_power_up_state
                       : pbseq_pkg::second_power_up_state;
        end
        pbseq_pkg::first_power_up_state, pbseq_pkg::second_power_up_state: begin
          if (pup_done) next_state = pbseq_pkg::powered_on_state;
        end
        pbseq_pkg::powered_on_state: begin
          if (uv || (!req_one && !req_two))
            next_state = pbseq_pkg::timed_power_down_state;
        end
        pbseq_pkg::timed_power_down_state: begin
          if (wait_done) next_state = pbseq_pkg::powered_off_state;
        end
        pbseq_pkg::hard_power_down_state: begin
          if (wait_done) next_state = pbseq_pkg::hard_reset_state;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state           <= pbseq_pkg::hard_power_down_state;
      armed           <= 1'b0;
      lp_valid        <= 1'b0;
      button_was_high <= 1'b1;
    end else begin
      state           <= next_state;
      armed           <= next_armed;
      lp_valid        <= next_lp_valid;
      button_was_high <= next_button_was_high;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic next_one, next_two, next_bs_oe, next_pg_oe;
  logic next_powered;
  always_comb begin
    next_one = 1'b0;
    next_two = 1'b0;
    unique case (next_state)
      pbseq_pkg::first_power_up_state, pbseq_pkg::second_power_up_state: begin
        next_one = 1'b1;
        next_two = SIMULTANEOUS || (reg_one_enable_out && one_good) || reg_two_enable_out;
      end
      pbseq_pkg::powered_on_state: begin
        next_one = req_one;
        next_two = req_two;
      end
      default: begin
        next_one = 1'b0;
        next_two = 1'b0;
      end
    endcase
    // once driven, status stays low a full debounce time so a short press is not lost
    next_bs_oe   = (is_on_group(next_state) && (deb_done || (bs_driving && !hold_done)))
                 ? pbseq_pkg::OE_DRIVE : pbseq_pkg::OE_RELEASE;
    // decided from the next state so power-good drops in the same cycle as the enables
    next_pg_oe   = (pg_done && is_on_group(next_state))
                 ? pbseq_pkg::OE_RELEASE : pbseq_pkg::OE_DRIVE;
    next_powered = is_on_group(next_state);
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_one_enable_out     <= 1'b0;
      reg_two_enable_out     <= 1'b0;
      button_status_oe_n_out <= pbseq_pkg::OE_RELEASE;
      power_good_oe_n_out    <= pbseq_pkg::OE_DRIVE;
      button_status_out      <= pbseq_pkg::PIN_LOW;
      power_good_out         <= pbseq_pkg::PIN_LOW;
      powered_out            <= 1'b0;
    end else begin
      reg_one_enable_out     <= next_one;
      reg_two_enable_out     <= next_two;
      button_status_oe_n_out <= next_bs_oe;
      power_good_oe_n_out    <= next_pg_oe;
      button_status_out      <= pbseq_pkg::PIN_LOW;
      power_good_out         <= pbseq_pkg::PIN_LOW;
      powered_out            <= next_powered;
    end
  end

endmodule : pbseq_core

/* File: test/pbseq_host_model.sv */
// host and regulator model: requests on command, in-regulation flags after a settle time
module pbseq_host_model #(
  parameter int unsigned SETTLE = 20
) (
  // clock
  input  wire logic       sys_clk_in,
  // from the sequencer
  input  wire logic       reg_one_enable_in,
  input  wire logic       reg_two_enable_in,
  // bench command
  input  wire logic [1:0] hold_in,
  // to the sequencer
  output logic            power_request_one_out,
  output logic            power_request_two_out,
  output logic            reg_one_good_out,
  output logic            reg_two_good_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned ramp_one = 0;
  int unsigned ramp_two = 0;
  initial {power_request_two_out, power_request_one_out} = 2'b00;
  initial {reg_two_good_out, reg_one_good_out} = 2'b00;
  // a disabled regulator loses regulation at once, so good never outlives enable
  always @(negedge sys_clk_in) begin
    ramp_one = reg_one_enable_in ? ramp_one + 1 : 0;
    ramp_two = reg_two_enable_in ? ramp_two + 1 : 0;
    reg_one_good_out <= (ramp_one > SETTLE);
    reg_two_good_out <= (ramp_two > SETTLE);
    power_request_one_out <= hold_in[0];
    power_request_two_out <= hold_in[1];
  end
endmodule : pbseq_host_model

/* File: test/pbseq_core_properties.sv */
// timing and level checks on the sequencer ports
module pbseq_core_properties #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic button_n_in,
  input wire logic reg_one_good_in,
  input wire logic reg_two_good_in,
  input wire logic reg_one_enable_out,
  input wire logic reg_two_enable_out,
  input wire logic button_status_oe_n_out,
  input wire logic power_good_oe_n_out,
  input wire logic powered_out
);
  int unsigned low_cnt;
  int unsigned good_cnt;
  int unsigned btn_cnt;
  logic        all_good;
  logic        stay_off;
  assign all_good = (reg_one_good_in || !reg_one_enable_out)
                 && (reg_two_good_in || !reg_two_enable_out)
                 && (reg_one_enable_out || reg_two_enable_out);
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt  <= 0;
      good_cnt <= 0;
      btn_cnt  <= 0;
    end else begin
      low_cnt  <= powered_out ? 0 : low_cnt + 1;
      good_cnt <= all_good ? good_cnt + 1 : 0;
      btn_cnt  <= button_n_in ? 0 : btn_cnt + 1;
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // ************************************************************
  // checks
  // ************************************************************
  // the first low cycle may still show enables from the last on cycle
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) stay_off <= 1'b0;
    else stay_off <= !powered_out;
  end
  chk_up_after_wait: assert property (
    $rose(powered_out) |-> low_cnt >= 999 * TICK_CYCLES) else $error("power-up too soon");
  chk_off_regs_off: assert property (
    (!powered_out && stay_off) |-> !reg_one_enable_out && !reg_two_enable_out)
    else $error("regulator on while off");
  chk_off_status_hiz: assert property (
    (!powered_out && stay_off) |-> button_status_oe_n_out) else $error("status driven while off");
  chk_off_pg_low: assert property (
    (!powered_out && stay_off) |-> !power_good_oe_n_out) else $error("power-good released off");
  chk_regs_need_on: assert property (
    (reg_one_enable_out || reg_two_enable_out) |-> powered_out) else $error("enable without on");
  chk_two_after_one: assert property (
    ($rose(reg_two_enable_out) && $past(reg_one_enable_out)) |-> reg_one_good_in)
    else $error("regulator two before one good");
  chk_pg_delay: assert property (
    $rose(power_good_oe_n_out) |-> good_cnt >= 229 * TICK_CYCLES) else $error("power-good early");
  chk_status_debounce: assert property (
    $fell(button_status_oe_n_out) |-> btn_cnt >= 49 * TICK_CYCLES) else $error("status not debounced");
  chk_status_min_low: assert property (
    $fell(button_status_oe_n_out) |=> !button_status_oe_n_out [*8]) else $error("status pulse short");
  cov_pg_up: cover property ($rose(power_good_oe_n_out));
  cov_status: cover property ($fell(button_status_oe_n_out));
  cov_two_on: cover property ($rose(reg_two_enable_out));
endmodule : pbseq_core_properties
bind pbseq_core pbseq_core_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .button_n_in(button_n_in),
  .reg_one_good_in(reg_one_good_in), .reg_two_good_in(reg_two_good_in),
  .reg_one_enable_out(reg_one_enable_out), .reg_two_enable_out(reg_two_enable_out),
  .button_status_oe_n_out(button_status_oe_n_out),
  .power_good_oe_n_out(power_good_oe_n_out), .powered_out(powered_out));

/* File: test/pushbutton_power_sequencer_test.sv */
// self-checking bench for the pushbutton power sequencer
module pushbutton_power_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  localparam int PW = 0, E1 = 1, E2 = 2, ST = 3, PG = 4;
  logic sys_clk = 1'b0, arst_n = 1'b0, btn_n = 1'b1, ext = 1'b0, uv = 1'b0, por = 1'b0;
  logic [1:0] hold = 2'b00;
  logic req1, req2, good1, good2, en1, en2, st_oe_n, pg_oe_n, pw, st_pin, pg_pin;
  logic [4:0] obs;
  int num_errors = 0, cmp_count = 0, waited;
  assign obs = {pg_oe_n, st_oe_n, en2, en1, pw};
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
  always #5 sys_clk = ~sys_clk;
  pbseq_core #(.TICK_CYCLES(T)) dut (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .button_n_in(btn_n),
    .power_request_one_in(req1), .power_request_two_in(req2), .ext_power_in(ext),
    .out_undervoltage_in(uv), .out_por_in(por), .reg_one_good_in(good1),
    .reg_two_good_in(good2), .reg_one_enable_out(en1), .reg_two_enable_out(en2),
    .button_status_out(st_pin), .button_status_oe_n_out(st_oe_n), .power_good_out(pg_pin),
    .power_good_oe_n_out(pg_oe_n), .powered_out(pw));
  pbseq_host_model host (
    .sys_clk_in(sys_clk), .reg_one_enable_in(en1), .reg_two_enable_in(en2),
    .hold_in(hold), .power_request_one_out(req1), .power_request_two_out(req2),
    .reg_one_good_out(good1), .reg_two_good_out(good2));
  task automatic wait_ms(input int ms);
    repeat (ms * T) @(negedge sys_clk);
  endtask : wait_ms
  task automatic wait_obs(input int i, input logic v, input int ms);
    waited = 0;
    while (obs[i] !== v && waited < ms * T) begin
      @(negedge sys_clk);
      waited++;
    end
    `CHK(obs[i], v)
  endtask : wait_obs
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_press_up();
    `CHK(obs[PW], 1'b0)
    wait_ms(1100);
    btn_n = 1'b0;
    wait_obs(PW, 1'b1, 450);
    `CHK(obs[E2:E1], 2'b01)
    wait_obs(E2, 1'b1, 20);
    wait_obs(PG, 1'b1, 260);
    `CHK(pg_pin, 1'b0)
    btn_n = 1'b1;
    wait_ms(4400);
    `CHK(obs[E2:E1], 2'b11)
    hold = 2'b01;
    wait_ms(700);
    `CHK(obs[E2:E1], 2'b01)
    hold = 2'b11;
    $display("test press_up done");
  endtask : t_press_up
  task automatic t_status_down();
    btn_n = 1'b0;
    wait_ms(60);
    `CHK(obs[ST], 1'b0)
    `CHK(st_pin, 1'b0)
    hold = 2'b00;
    wait_obs(PW, 1'b0, 10);
    `CHK(obs[ST:E1], 3'b100)
    ext = 1'b1;
    hold = 2'b11;
    wait_ms(900);
    `CHK(obs[PW], 1'b0)
    ext = 1'b0;
    hold = 2'b00;
    wait_ms(300);
    `CHK(obs[PW], 1'b0)
    btn_n = 1'b1;
    wait_ms(100);
    `CHK(obs[PW], 1'b0)
    $display("test status_down done");
  endtask : t_status_down
  task automatic t_request_uv();
    hold = 2'b10;
    wait_obs(PW, 1'b1, 10);
    `CHK(obs[E2:E1], 2'b10)
    wait_obs(PG, 1'b1, 300);
    uv = 1'b1;
    wait_obs(PW, 1'b0, 10);
    `CHK({obs[PG], obs[E2:E1]}, 3'b000)
    uv = 1'b0;
    hold = 2'b00;
    ext = 1'b1;
    wait_obs(PW, 1'b1, 1200);
    `CHK(obs[E1], 1'b1)
    hold = 2'b11;
    ext = 1'b0;
    $display("test request_uv done");
  endtask : t_request_uv
  task automatic t_long_press();
    btn_n = 1'b0;
    wait_obs(PW, 1'b0, 5100);
    hold = 2'b00;
    `CHK(waited > 4900 * T, 1'b1)
    `CHK({obs[PG], obs[E2:E1]}, 3'b000)
    btn_n = 1'b1;
    wait_ms(1100);
    `CHK(obs[PW], 1'b0)
    $display("test long_press done");
  endtask : t_long_press
  task automatic t_por();
    hold = 2'b01;
    wait_obs(PW, 1'b1, 10);
    por = 1'b1;
    wait_obs(PW, 1'b0, 10);
    por = 1'b0;
    hold = 2'b00;
    wait_ms(1100);
    `CHK(obs[E2:E1], 2'b00)
    $display("test por done");
  endtask : t_por
  initial begin
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    t_press_up();
    t_status_down();
    t_request_uv();
    t_long_press();
    t_por();
    test_done();
  end
  // the whole sequence needs about 68000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    $display("watchdog expired");
    test_done();
  end
endmodule : pushbutton_power_sequencer_test
